// ### ics_regs.svh
/*
 * Constants of the instruction sequencer: word layout, address regions,
 * operation codes and pulse timing.
 * Assumes it is included by its bare name from the package and the top module.
 */
`ifndef ICS_REGS_SVH
`define ICS_REGS_SVH

// ----------------------------------------
// Word layout
// ----------------------------------------
`define ICS_WORD_W      36
`define ICS_ADDR_W      15
`define ICS_ACC_W       72
`define ICS_OP_HI       35
`define ICS_OP_LO       30
`define ICS_U_HI        29
`define ICS_U_LO        15
`define ICS_V_HI        14
`define ICS_V_LO        0
`define ICS_CNT_W       7
`define ICS_NUM_OPS     6'h29

// ----------------------------------------
// Address regions
// ----------------------------------------
`define ICS_BAD_LO      15'h3000
`define ICS_BAD_HI      15'h31ff
`define ICS_Q_LO        15'h3200
`define ICS_Q_HI        15'h33ff
`define ICS_A_LO        15'h3400
`define ICS_A_HI        15'h3fff

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define ICS_OP_XMIT     6'h09
`define ICS_OP_LDQ      6'h0a
`define ICS_OP_LDA      6'h0b
`define ICS_OP_SHQ      6'h12
`define ICS_OP_SHA      6'h13
`define ICS_OP_ADD      6'h20
`define ICS_OP_SUB      6'h21
`define ICS_OP_MUL      6'h22
`define ICS_OP_DIV      6'h23
`define ICS_OP_JMP      6'h24
`define ICS_OP_STOP     6'h27

// ----------------------------------------
// Timing
// ----------------------------------------
`define ICS_CLK_NS      5
`define ICS_PULSE_NS    2000
`define ICS_PULSE_CYC   (`ICS_PULSE_NS / `ICS_CLK_NS)

`endif

// ### ics_pkg.sv
/*
 * Types of the instruction sequencer.
 * Assumes ics_regs.svh is on the include path.
 */
`include "ics_regs.svh"

package ics_pkg;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_FETCH,
		ST_FETCH_WAIT,
		ST_DECODE,
		ST_READ,
		ST_READ_WAIT,
		ST_EXEC,
		ST_WRITE,
		ST_WRITE_WAIT,
		ST_SHIFT
	} ics_state_t;

	typedef enum logic [3:0] {
		CL_NOP,
		CL_XMIT,
		CL_LDQ,
		CL_LDA,
		CL_SHQ,
		CL_SHA,
		CL_ADD,
		CL_SUB,
		CL_MUL,
		CL_DIV,
		CL_JMP,
		CL_STOP,
		CL_ILLEGAL
	} ics_class_t;

	typedef enum logic [1:0] {
		RG_STORE,
		RG_Q,
		RG_ACC,
		RG_BAD
	} ics_region_t;

	typedef struct packed {
		logic                     req;
		logic                     we;
		logic [`ICS_ADDR_W-1:0]   addr;
		logic [`ICS_WORD_W-1:0]   wdata;
	} ics_mem_req_t;

	typedef struct packed {
		logic                     ack;
		logic [`ICS_WORD_W-1:0]   rdata;
	} ics_mem_rsp_t;

	typedef struct packed {
		ics_state_t               st;
		ics_class_t               cls;
		logic [`ICS_ADDR_W-1:0]   pc;
		logic [`ICS_WORD_W-1:0]   instr;
		logic [`ICS_WORD_W-1:0]   x;
		logic [`ICS_WORD_W-1:0]   q;
		logic [`ICS_ACC_W-1:0]    acc;
		logic [`ICS_CNT_W-1:0]    cnt;
		logic                     running;
		logic                     halted;
		logic                     illegal;
		ics_mem_req_t             mem;
	} ics_regs_t;

endpackage

// ### ics_pulse.sv
/*
 * Master pulse source: one single-cycle tick every PERIOD_CYC clocks.
 * Assumes a synchronous active-low reset on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ics_pulse #(
	parameter int PERIOD_CYC = 400
) (
	// Clock and reset
	input  wire logic ref_clk_in,
	input  wire logic resetn_in,
	// Pulse
	output var  logic tick_out
);

	localparam int CW = (PERIOD_CYC > 1) ? $clog2(PERIOD_CYC) : 1;

	generate
		if (PERIOD_CYC < 1) begin : g_bad
			$error("ics_pulse: PERIOD_CYC must be at least one");
		end
	endgenerate

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} ics_pulse_t;

	ics_pulse_t s;
	ics_pulse_t next_s;

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.cnt == CW'(PERIOD_CYC - 1)) begin
			next_s.cnt = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + CW'(1);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick_out = s.tick;

endmodule

`default_nettype wire

// ### ics_ctrl.sv
/*
 * Instruction sequencer and principal registers of a 36-bit word machine:
 * program address counter, instruction register, decode into pulse
 * sequences, transfer, multiplier/quotient and double-length sum registers.
 * Assumes an external storage unit that answers each request with a
 * one-cycle ack, and a starter that supplies the first instruction address.
 */

// What this block does
// - Every instruction is a 36-bit word; bits 35 to 30 are the opcode.
// - Bits 29 to 15 are the first address, bits 14 to 0 the second.
// - Decode 41 opcodes from six opcode stages; 11 get a specific pulse sequence, the other 30 act as no-ops.
// - A 15-bit program address fetches the next instruction into the instruction register.
// - The instruction register holds its word until the next fetch replaces it.
// - The program address counts up by one after each instruction fetch.
// - Operands are read from the selected address field and moved to their register.
// - Sequencing advances on a master pulse every two microseconds, gated by state; the three wait states advance on the storage ack and idle on start instead.
// - Each register operation updates all stages at once, in parallel.
// - The transfer register carries every operand word to its destination; fetched instructions go straight to the instruction register.
// - The transfer register supplies addend, subtrahend, multiplicand or divisor.
// - The multiplier/quotient register is addressable and holds multiplier and quotient.
// - Shifting it rotates one place left per step for the commanded count.
// - The sum register has 72 stages: an upper and a lower 36-bit word.
// - The sum register holds sums, products, dividends and the final remainder.
// - Shifting the sum register rotates all 72 bits left by the count.
// - The sum register keeps full-width sums and complete 72-bit products.
// - A read puts the word into the transfer register; a write stores it.
`timescale 1ns/1ps
`default_nettype none
`include "ics_regs.svh"

module ics_ctrl #(
	parameter int PULSE_CYC = `ICS_PULSE_CYC
) (
	// Clock and reset
	input  wire logic                     ref_clk_in,
	input  wire logic                     resetn_in,
	// Start
	input  wire logic                     start_in,
	input  wire logic [`ICS_ADDR_W-1:0]   start_addr_in,
	// Storage
	output var  ics_pkg::ics_mem_req_t    mem_out,
	input  wire ics_pkg::ics_mem_rsp_t    mem_in,
	// Status and registers
	output var  logic                     running_out,
	output var  logic                     halted_out,
	output var  logic                     illegal_out,
	output var  logic [`ICS_ADDR_W-1:0]   pc_out,
	output var  logic [`ICS_WORD_W-1:0]   instr_out,
	output var  logic [`ICS_WORD_W-1:0]   x_out,
	output var  logic [`ICS_WORD_W-1:0]   q_out,
	output var  logic [`ICS_WORD_W-1:0]   upper_word_out,
	output var  logic [`ICS_WORD_W-1:0]   lower_word_out
);

	generate
		if (PULSE_CYC < 2) begin : g_bad
			$error("ics_ctrl: PULSE_CYC must be at least two");
		end
	endgenerate

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic ics_pkg::ics_class_t op_class(input logic [5:0] op);
		ics_pkg::ics_class_t c;
		c = ics_pkg::CL_NOP;
		if (op >= `ICS_NUM_OPS) begin
			c = ics_pkg::CL_ILLEGAL;
		end else begin
			case (op)
				`ICS_OP_XMIT: c = ics_pkg::CL_XMIT;
				`ICS_OP_LDQ:  c = ics_pkg::CL_LDQ;
				`ICS_OP_LDA:  c = ics_pkg::CL_LDA;
				`ICS_OP_SHQ:  c = ics_pkg::CL_SHQ;
				`ICS_OP_SHA:  c = ics_pkg::CL_SHA;
				`ICS_OP_ADD:  c = ics_pkg::CL_ADD;
				`ICS_OP_SUB:  c = ics_pkg::CL_SUB;
				`ICS_OP_MUL:  c = ics_pkg::CL_MUL;
				`ICS_OP_DIV:  c = ics_pkg::CL_DIV;
				`ICS_OP_JMP:  c = ics_pkg::CL_JMP;
				`ICS_OP_STOP: c = ics_pkg::CL_STOP;
				default:      c = ics_pkg::CL_NOP;
			endcase
		end
		return c;
	endfunction

	// Q and the sum register answer inside the block; storage is not asked
	function automatic ics_pkg::ics_region_t region(input logic [`ICS_ADDR_W-1:0] a);
		ics_pkg::ics_region_t r;
		r = ics_pkg::RG_STORE;
		if (a >= `ICS_BAD_LO && a <= `ICS_BAD_HI) begin
			r = ics_pkg::RG_BAD;
		end else if (a >= `ICS_Q_LO && a <= `ICS_Q_HI) begin
			r = ics_pkg::RG_Q;
		end else if (a >= `ICS_A_LO && a <= `ICS_A_HI) begin
			r = ics_pkg::RG_ACC;
		end
		return r;
	endfunction

	// ----------------------------------------
	// Master pulse
	// ----------------------------------------
	logic tick;

	ics_pulse #(
		.PERIOD_CYC (PULSE_CYC)
	) u_pulse (
		.ref_clk_in (ref_clk_in),
		.resetn_in  (resetn_in),
		.tick_out   (tick)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	ics_pkg::ics_regs_t s;
	ics_pkg::ics_regs_t next_s;

	logic [5:0]              op;
	logic [`ICS_ADDR_W-1:0]  u_addr;
	logic [`ICS_ADDR_W-1:0]  v_addr;

	assign op     = s.instr[`ICS_OP_HI:`ICS_OP_LO];
	assign u_addr = s.instr[`ICS_U_HI:`ICS_U_LO];
	assign v_addr = s.instr[`ICS_V_HI:`ICS_V_LO];

	always_comb begin
		logic [`ICS_ACC_W-1:0] quo;
		quo = '0;
		next_s = s;
		case (s.st)
			ics_pkg::ST_IDLE: begin
				if (start_in) begin
					next_s.pc = start_addr_in;
					next_s.running = 1'b1;
					next_s.halted = 1'b0;
					next_s.illegal = 1'b0;
					next_s.st = ics_pkg::ST_FETCH;
				end
			end
			ics_pkg::ST_FETCH: begin
				if (tick) begin
					next_s.mem.req = 1'b1;
					next_s.mem.we = 1'b0;
					next_s.mem.addr = s.pc;
					next_s.st = ics_pkg::ST_FETCH_WAIT;
				end
			end
			ics_pkg::ST_FETCH_WAIT: begin
				if (mem_in.ack) begin
					next_s.instr = mem_in.rdata;
					next_s.pc = s.pc + 15'h0001;
					next_s.mem.req = 1'b0;
					next_s.st = ics_pkg::ST_DECODE;
				end
			end
			ics_pkg::ST_DECODE: begin
				if (tick) begin
					next_s.cls = op_class(op);
					next_s.cnt = u_addr[`ICS_CNT_W-1:0];
					case (op_class(op))
						ics_pkg::CL_NOP: next_s.st = ics_pkg::ST_FETCH;
						ics_pkg::CL_JMP: begin
							next_s.pc = v_addr;
							next_s.st = ics_pkg::ST_FETCH;
						end
						ics_pkg::CL_STOP: begin
							next_s.running = 1'b0;
							next_s.halted = 1'b1;
							next_s.st = ics_pkg::ST_IDLE;
						end
						ics_pkg::CL_ILLEGAL: begin
							next_s.running = 1'b0;
							next_s.illegal = 1'b1;
							next_s.st = ics_pkg::ST_IDLE;
						end
						ics_pkg::CL_SHQ,
						ics_pkg::CL_SHA: next_s.st = ics_pkg::ST_SHIFT;
						default: next_s.st = ics_pkg::ST_READ;
					endcase
				end
			end
			ics_pkg::ST_READ: begin
				if (tick) begin
					case (region(u_addr))
						ics_pkg::RG_Q: begin
							next_s.x = s.q;
							next_s.st = ics_pkg::ST_EXEC;
						end
						ics_pkg::RG_ACC: begin
							next_s.x = s.acc[`ICS_WORD_W-1:0];
							next_s.st = ics_pkg::ST_EXEC;
						end
						ics_pkg::RG_BAD: begin
							next_s.running = 1'b0;
							next_s.illegal = 1'b1;
							next_s.st = ics_pkg::ST_IDLE;
						end
						default: begin
							next_s.mem.req = 1'b1;
							next_s.mem.we = 1'b0;
							next_s.mem.addr = u_addr;
							next_s.st = ics_pkg::ST_READ_WAIT;
						end
					endcase
				end
			end
			ics_pkg::ST_READ_WAIT: begin
				if (mem_in.ack) begin
					next_s.x = mem_in.rdata;
					next_s.mem.req = 1'b0;
					next_s.st = ics_pkg::ST_EXEC;
				end
			end
			ics_pkg::ST_EXEC: begin
				if (tick) begin
					next_s.st = ics_pkg::ST_FETCH;
					case (s.cls)
						ics_pkg::CL_XMIT: next_s.st = ics_pkg::ST_WRITE;
						ics_pkg::CL_LDQ:  next_s.q = s.x;
						ics_pkg::CL_LDA:  next_s.acc = {36'h0, s.x};
						ics_pkg::CL_ADD:  next_s.acc = s.acc + {36'h0, s.x};
						ics_pkg::CL_SUB:  next_s.acc = s.acc - {36'h0, s.x};
						ics_pkg::CL_MUL:  next_s.acc = {36'h0, s.q} * {36'h0, s.x};
						ics_pkg::CL_DIV: begin
							// A zero divisor stops the machine rather than corrupt Q
							if (s.x == '0) begin
								next_s.running = 1'b0;
								next_s.illegal = 1'b1;
								next_s.st = ics_pkg::ST_IDLE;
							end else begin
								quo = s.acc / {36'h0, s.x};
								next_s.q = quo[`ICS_WORD_W-1:0];
								next_s.acc = s.acc % {36'h0, s.x};
							end
						end
						default: next_s.st = ics_pkg::ST_FETCH;
					endcase
				end
			end
			ics_pkg::ST_WRITE: begin
				if (tick) begin
					case (region(v_addr))
						ics_pkg::RG_Q: begin
							next_s.q = s.x;
							next_s.st = ics_pkg::ST_FETCH;
						end
						ics_pkg::RG_ACC: begin
							next_s.acc[`ICS_WORD_W-1:0] = s.x;
							next_s.st = ics_pkg::ST_FETCH;
						end
						ics_pkg::RG_BAD: begin
							next_s.running = 1'b0;
							next_s.illegal = 1'b1;
							next_s.st = ics_pkg::ST_IDLE;
						end
						default: begin
							next_s.mem.req = 1'b1;
							next_s.mem.we = 1'b1;
							next_s.mem.addr = v_addr;
							next_s.mem.wdata = s.x;
							next_s.st = ics_pkg::ST_WRITE_WAIT;
						end
					endcase
				end
			end
			ics_pkg::ST_WRITE_WAIT: begin
				if (mem_in.ack) begin
					next_s.mem.req = 1'b0;
					next_s.mem.we = 1'b0;
					next_s.st = ics_pkg::ST_FETCH;
				end
			end
			ics_pkg::ST_SHIFT: begin
				// One place per master pulse; a long count costs time, not logic
				if (tick) begin
					if (s.cnt == '0) begin
						next_s.st = ics_pkg::ST_FETCH;
					end else begin
						next_s.cnt = s.cnt - 7'h01;
						if (s.cls == ics_pkg::CL_SHQ) begin
							next_s.q = {s.q[34:0], s.q[35]};
						end else begin
							next_s.acc = {s.acc[70:0], s.acc[71]};
						end
					end
				end
			end
			default: next_s.st = ics_pkg::ST_IDLE;
		endcase
	end

	// Whole state updates on one edge, every stage in parallel
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign mem_out        = s.mem;
	assign running_out    = s.running;
	assign halted_out     = s.halted;
	assign illegal_out    = s.illegal;
	assign pc_out         = s.pc;
	assign instr_out      = s.instr;
	assign x_out          = s.x;
	assign q_out          = s.q;
	assign upper_word_out = s.acc[`ICS_ACC_W-1:`ICS_WORD_W];
	assign lower_word_out = s.acc[`ICS_WORD_W-1:0];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);

	sequence fetch_done_s;
		s.st == ics_pkg::ST_FETCH_WAIT && mem_in.ack;
	endsequence

	sequence shift_step_s;
		s.st == ics_pkg::ST_SHIFT && tick && s.cnt != '0;
	endsequence

	reset_clear_a: assert property ($past(!resetn_in) |->
		s.pc == '0 && s.instr == '0 && s.st == ics_pkg::ST_IDLE && !mem_out.req)
		else $error("state not cleared after reset");

	instr_load_a: assert property (fetch_done_s |=>
		s.instr == $past(mem_in.rdata) && s.st == ics_pkg::ST_DECODE)
		else $error("fetched word not in instruction register");

	instr_hold_a: assert property ($changed(s.instr) |->
		$past(s.st) == ics_pkg::ST_FETCH_WAIT)
		else $error("instruction register changed outside fetch");

	pc_count_a: assert property (fetch_done_s |=> s.pc == $past(s.pc) + 15'h0001)
		else $error("program address did not count");

	fetch_addr_a: assert property (s.st == ics_pkg::ST_FETCH && tick |=>
		mem_out.req && !mem_out.we && mem_out.addr == $past(s.pc))
		else $error("fetch not from program address");

	pulse_gate_a: assert property (s.st == ics_pkg::ST_EXEC && !tick |=>
		s.st == ics_pkg::ST_EXEC)
		else $error("sequence advanced without master pulse");

	operand_addr_a: assert property (s.st == ics_pkg::ST_READ_WAIT |->
		mem_out.addr == s.instr[29:15] && mem_out.req)
		else $error("operand read not from first address field");

	write_data_a: assert property (s.st == ics_pkg::ST_WRITE_WAIT |->
		mem_out.we && mem_out.wdata == s.x && mem_out.addr == s.instr[14:0])
		else $error("storage write does not carry transfer register");

	q_rotate_a: assert property (shift_step_s ##0 s.cls == ics_pkg::CL_SHQ |=>
		s.q == {$past(s.q[34:0]), $past(s.q[35])} && s.cnt == $past(s.cnt) - 7'h01)
		else $error("multiplier register rotate wrong");

	acc_rotate_a: assert property (shift_step_s ##0 s.cls == ics_pkg::CL_SHA |=>
		s.acc == {$past(s.acc[70:0]), $past(s.acc[71])})
		else $error("sum register rotate wrong");

	shift_zero_a: assert property (s.st == ics_pkg::ST_SHIFT && tick && s.cnt == '0 |=>
		$stable(s.q) && $stable(s.acc) && s.st == ics_pkg::ST_FETCH)
		else $error("zero count shift changed a register");

	full_product_a: assert property (s.st == ics_pkg::ST_EXEC && tick && s.cls == ics_pkg::CL_MUL |=>
		s.acc == {36'h0, $past(s.q)} * {36'h0, $past(s.x)})
		else $error("product not held at full width");

	illegal_op_a: assert property (s.st == ics_pkg::ST_DECODE && tick && op >= 6'h29 |=>
		s.illegal && !s.running && s.st == ics_pkg::ST_IDLE)
		else $error("opcode outside repertoire not refused");

endmodule

`default_nettype wire

// ### ics_mem_model.sv
/*
 * Storage partner of the sequencer: a word array that answers each request
 * with a one-cycle ack after delay_in extra cycles.
 * Assumes one outstanding request whose fields stand until the ack.
 */
`timescale 1ns/1ps
`default_nettype none

module ics_mem_model (
	// Clock and reset
	input  wire logic                  ref_clk_in,
	input  wire logic                  resetn_in,
	// Storage port
	input  wire ics_pkg::ics_mem_req_t mem_in,
	input  wire logic [3:0]            delay_in,
	output var  ics_pkg::ics_mem_rsp_t mem_out
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [35:0]           mem [0:32767];
	ics_pkg::ics_mem_req_t held;
	logic                  served;
	int                    wait_cnt;
	int                    err_count = 0;

	// ----------------------------------------
	// Answer
	// ----------------------------------------
	// Unanswered data toggles so a stale read never matches by luck
	always @(posedge ref_clk_in) begin
		mem_out.ack <= 1'b0;
		mem_out.rdata <= ~mem_out.rdata;
		if (!resetn_in) begin
			mem_out.rdata <= 36'h0;
			served <= 1'b0;
			wait_cnt <= 0;
		end else if (!mem_in.req) begin
			served <= 1'b0;
			wait_cnt <= 0;
		end else if (!served) begin
			if (wait_cnt > 0 && mem_in !== held)
				err_count <= err_count + 1;
			held <= mem_in;
			wait_cnt <= wait_cnt + 1;
			if (wait_cnt >= int'(delay_in)) begin
				mem_out.ack <= 1'b1;
				served <= 1'b1;
				if (mem_in.we)
					mem[mem_in.addr] <= mem_in.wdata;
				else
					mem_out.rdata <= mem[mem_in.addr];
			end
		end
	end
endmodule

`default_nettype wire

// ### tb.sv
/*
 * Self-checking bench of the sequencer, with the storage model behind it.
 * Assumes a short master pulse period of 4 clocks.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ics_regs.svh"

module tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic                  ref_clk_in    = 1'b0;
	logic                  resetn_in     = 1'b0;
	logic                  start_in      = 1'b0;
	logic [14:0]           start_addr_in = 15'h0;
	logic [3:0]            delay_in      = 4'h0;
	ics_pkg::ics_mem_req_t mem_req;
	ics_pkg::ics_mem_rsp_t mem_rsp;
	logic                  running, halted, illegal;
	logic [14:0]           pc;
	logic [35:0]           instr, x, q, upw, low;
	int                    fail_count    = 0;
	int                    total_checks  = 0;
	logic                  prev_req      = 1'b0;
	logic                  seen          = 1'b0;
	int                    gap           = 0;

	always #2.5 ref_clk_in = ~ref_clk_in;

	ics_ctrl #(.PULSE_CYC(4)) ics_ctrl_inst (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
		.start_in(start_in), .start_addr_in(start_addr_in), .mem_out(mem_req), .mem_in(mem_rsp),
		.running_out(running), .halted_out(halted), .illegal_out(illegal), .pc_out(pc),
		.instr_out(instr), .x_out(x), .q_out(q), .upper_word_out(upw), .lower_word_out(low));

	ics_mem_model ics_mem_model_inst (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
		.mem_in(mem_req), .delay_in(delay_in), .mem_out(mem_rsp));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check_word(input string n, input logic [35:0] e, input logic [35:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic check_addr(input string n, input logic [14:0] e, input logic [14:0] g);
		check_word(n, {21'h0, e}, {21'h0, g});
	endtask

	task automatic check_flag(input string n, input logic e, input logic g);
		check_word(n, {35'h0, e}, {35'h0, g});
	endtask

	task automatic tick_n(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask

	function automatic logic [35:0] ins(input logic [5:0] op, input logic [14:0] u, input logic [14:0] v);
		return {op, u, v};
	endfunction

	task automatic put(input logic [14:0] a, input logic [35:0] w);
		ics_mem_model_inst.mem[a] = w;
	endtask

	task automatic print_verdict;
		if (fail_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Requests leave only just after a master pulse, so rises are whole periods apart
	always @(posedge ref_clk_in) begin
		prev_req <= mem_req.req;
		gap <= gap + 1;
		if (!resetn_in)
			seen <= 1'b0;
		else if (mem_req.req === 1'b1 && prev_req === 1'b0) begin
			if (seen)
				check_flag("req spacing", 1'b1, gap % 4 == 0);
			seen <= 1'b1;
			gap <= 1;
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic do_reset;
		resetn_in = 1'b0;
		tick_n(6);
		resetn_in = 1'b1;
		tick_n(1);
		check_addr("pc", 15'h0, pc);
		check_word("instr", 36'h0, instr);
		check_flag("running", 1'b0, running);
		tick_n(20);
		check_flag("req idle", 1'b0, mem_req.req);
	endtask

	task automatic start_at(input logic [14:0] a);
		start_in = 1'b1;
		start_addr_in = a;
		tick_n(1);
		start_in = 1'b0;
	endtask

	task automatic run_prog(input logic [14:0] a, input logic [3:0] d);
		int n;
		delay_in = d;
		start_at(a);
		check_flag("running", 1'b1, running);
		check_addr("start pc", a, pc);
		tick_n(2);
		start_at(15'h7777);
		for (n = 0; n < 3000 && running === 1'b1; n++)
			tick_n(1);
		check_flag("finished", 1'b0, running);
	endtask

	task automatic test_arith;
		logic [35:0] q0;
		logic [71:0] p;
		q0 = 36'h800000001;
		put(15'h100, ins(`ICS_OP_LDQ, 15'h200, 15'h0));
		put(15'h101, ins(`ICS_OP_MUL, 15'h201, 15'h0));
		put(15'h102, ins(`ICS_OP_SHA, 15'h4, 15'h0));
		put(15'h103, ins(`ICS_OP_SHQ, 15'h0, 15'h0));
		put(15'h104, ins(`ICS_OP_SHQ, 15'h3, 15'h0));
		put(15'h105, ins(`ICS_OP_XMIT, 15'h202, 15'h203));
		put(15'h106, ins(`ICS_OP_JMP, 15'h0, 15'h300));
		put(15'h300, ins(`ICS_OP_ADD, 15'h204, 15'h0));
		put(15'h301, ins(`ICS_OP_STOP, 15'h0, 15'h0));
		put(15'h200, q0);
		put(15'h201, 36'hfffffffff);
		put(15'h202, 36'h5a5a5a5a5);
		put(15'h204, 36'h00000000f);
		p = {36'h0, q0} * {36'h0, 36'hfffffffff};
		p = {p[67:0], p[71:68]} + 72'hf;
		run_prog(15'h100, 4'h0);
		check_word("q", {q0[32:0], q0[35:33]}, q);
		check_word("upper", p[71:36], upw);
		check_word("lower", p[35:0], low);
		check_word("x", 36'hf, x);
		check_word("copy", 36'h5a5a5a5a5, ics_mem_model_inst.mem[15'h203]);
		check_addr("pc", 15'h302, pc);
		check_word("instr", ins(`ICS_OP_STOP, 15'h0, 15'h0), instr);
		check_flag("halted", 1'b1, halted);
	endtask

	task automatic test_illegal;
		logic [35:0] w [4];
		w[0] = ins(6'h29, 15'h0, 15'h0);
		w[1] = ins(`ICS_OP_XMIT, 15'h3000, 15'h10);
		w[2] = ins(`ICS_OP_DIV, 15'h214, 15'h0);
		w[3] = ins(`ICS_OP_XMIT, 15'h214, 15'h3100);
		put(15'h214, 36'h0);
		for (int i = 0; i < 4; i++) begin
			put(15'h500 + 15'(i), w[i]);
			run_prog(15'h500 + 15'(i), 4'h1);
			check_flag("illegal", 1'b1, illegal);
			check_word("instr", w[i], instr);
			check_addr("pc", 15'h501 + 15'(i), pc);
		end
	endtask

	task automatic test_div;
		put(15'h400, ins(`ICS_OP_LDA, 15'h210, 15'h0));
		put(15'h401, ins(`ICS_OP_DIV, 15'h211, 15'h0));
		put(15'h402, ins(`ICS_OP_XMIT, 15'h3200, 15'h212));
		put(15'h403, ins(`ICS_OP_XMIT, 15'h3400, 15'h213));
		put(15'h404, ins(`ICS_OP_SHA, 15'h0, 15'h0));
		put(15'h405, ins(`ICS_OP_SUB, 15'h215, 15'h0));
		// A no-op must not touch its field, even an illegal address
		put(15'h406, ins(6'h01, 15'h3000, 15'h0));
		put(15'h407, ins(`ICS_OP_XMIT, 15'h216, 15'h3400));
		put(15'h408, ins(`ICS_OP_XMIT, 15'h213, 15'h3200));
		put(15'h409, ins(`ICS_OP_STOP, 15'h0, 15'h0));
		put(15'h210, 36'h123456789);
		put(15'h211, 36'h000000010);
		put(15'h215, 36'h00000000a);
		put(15'h216, 36'h000000123);
		run_prog(15'h400, 4'h3);
		check_flag("illegal", 1'b0, illegal);
		check_word("q", 36'h000000009, q);
		check_word("upper", 36'hfffffffff, upw);
		check_word("lower", 36'h000000123, low);
		check_word("q store", 36'h012345678, ics_mem_model_inst.mem[15'h212]);
		check_word("acc store", 36'h9, ics_mem_model_inst.mem[15'h213]);
		check_addr("pc", 15'h40a, pc);
	endtask

	task automatic test_reset_mid;
		put(15'h600, ins(`ICS_OP_JMP, 15'h0, 15'h600));
		start_at(15'h600);
		tick_n(15);
		do_reset();
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		do_reset();
		test_arith();
		test_illegal();
		test_div();
		test_reset_mid();
		check_flag("fields held", 1'b1, ics_mem_model_inst.err_count == 0);
		print_verdict();
	end

	initial begin
		#200000;
		fail_count++;
		print_verdict();
	end
endmodule

`default_nettype wire
